/* far_side_pins.sv */
// Far side of the pins: memories and peripherals
// Assumes out and oe come straight from the block's pins
module far_side_pins (
  // Pin drive
  input wire logic [10:0] out,
  input wire logic [10:0] oe,
  // Wire level
  output logic [10:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven wires show the inverse of their last level
  always @(out, oe)
    level = (oe & out) | (~oe & ~level);
endmodule

/* pin_cell.v */
// One pin: chooses drive level and enable for the present state
// Assumes state code and settings come from logic on the same clock
`include "pin_state_consts.vh"
module pin_cell (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control
  input wire [1:0] state,
  input wire func_sel,
  input wire func_val,
  input wire gpio_oe,
  input wire gpio_val,
  input wire sw_float,
  input wire sw_high,
  input wire rel_float,
  // Pin
  output reg pin_out_ff,
  output reg pin_oe_ff
);
  reg nxt_pin_out;
  reg nxt_pin_oe;
  always @*
  begin
    nxt_pin_out = pin_out_ff;
    nxt_pin_oe = pin_oe_ff;
    case (state)
      `ST_RUN:
      begin
        nxt_pin_oe = func_sel | gpio_oe;
        nxt_pin_out = func_sel ? func_val : gpio_val;
      end
      `ST_SWSTBY:
      begin
        if (sw_float)
          nxt_pin_oe = 1'b0;
        else if (sw_high)
        begin
          nxt_pin_oe = 1'b1;
          nxt_pin_out = 1'b1;
        end
      end
      `ST_BUSREL:
      begin
        if (rel_float)
          nxt_pin_oe = 1'b0;
      end
      `ST_HWSTBY:
      begin
        nxt_pin_oe = 1'b0;
      end
      default:
      begin
        nxt_pin_oe = 1'b0;
      end
    endcase
  end
  // Hold otherwise: an input stays floating, an output keeps its level
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end
endmodule

/* pin_state_consts.vh */
// Constants for the standby pin state control block
// Assumes inclusion by bare name from the design files
`ifndef PIN_STATE_CONSTS_VH
`define PIN_STATE_CONSTS_VH
`define MODE_W 3
`define MODE_SINGLE_LO 3'h6
`define MODE_ADDR_LO 3'h3
`define MODE_ADDR_HI 3'h5
`define MODE_EXT_LO 3'h1
`define ST_RUN 2'h0
`define ST_SWSTBY 2'h1
`define ST_BUSREL 2'h2
`define ST_HWSTBY 2'h3
`endif

/* spsc_asserts.sv */
// Checker for the standby pin state control
// Assumes it sees only the top module's ports
module spsc_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] op_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic bus_release_req,
  input wire logic standby_output_keep,
  input wire logic upper_addr_bit23_enable,
  input wire logic upper_addr_bit20_enable,
  input wire logic chip_select7_enable,
  input wire logic [23:20] addr_hi,
  input wire logic [7:0] chip_sel_n,
  input wire logic [4:2] p8_ddr,
  input wire logic bus_released_ff,
  input wire logic [4:2] p8_out,
  input wire logic [4:2] p8_oe,
  input wire logic [7:4] pa_out,
  input wire logic [7:4] pa_oe,
  input wire logic [3:0] pb_out,
  input wire logic [3:0] pb_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire run = !hw_standby && !sw_standby && !bus_released_ff;
  wire sws = !hw_standby && sw_standby;
  wire rls = !hw_standby && !sw_standby && bus_released_ff;
  wire ext = op_mode >= 3'h1 && op_mode <= 3'h5;
  wire adr = op_mode >= 3'h3 && op_mode <= 3'h5;
  a_hw_all_float: assert property (hw_standby |=>
    p8_oe == 3'h0 && pa_oe == 4'h0 && pb_oe == 4'h0) else $error("pin driven");
  a_single_no_release: assert property (op_mode >= 3'h6 |=>
    !bus_released_ff) else $error("bus released");
  a_addr_run_out: assert property (run && adr
    && !upper_addr_bit23_enable
    |=> pa_oe[6] && pa_out[6] == $past(addr_hi[23]))
    else $error("addr pin wrong");
  a_addr_sw_float: assert property (sws && adr
    && !upper_addr_bit23_enable
    && !standby_output_keep |=> !pa_oe[6]) else $error("addr drives");
  a_io_release_hold: assert property (rls && adr
    && upper_addr_bit23_enable
    |=> $stable(pa_oe[6]) && $stable(pa_out[6]))
    else $error("io not held");
  a_a20_run_out: assert property (run && op_mode == 3'h5 &&
    !upper_addr_bit20_enable |=> pa_out[7] == $past(addr_hi[20]))
    else $error("a20 wrong");
  a_cs_sw_high: assert property (sws && ext &&
    chip_select7_enable
    && standby_output_keep |=> pb_oe[0] && pb_out[0]) else $error("cs low");
  a_cs_gpio_hold: assert property (sws && ext &&
    !chip_select7_enable
    |=> $stable(pb_out[0]) && $stable(pb_oe[0])) else $error("gpio moved");
  a_p8_cs_run: assert property (run && ext && p8_ddr[2]
    |=> p8_oe[2] && p8_out[2] == $past(chip_sel_n[2])) else $error("cs2 bad");
  c_release: cover property (bus_released_ff);
  c_sw_keep: cover property (sws && standby_output_keep);
  c_hw: cover property (hw_standby);
endmodule
bind standby_pin_state_control spsc_asserts i_chk (.*);

/* standby_pin_state_control.v */
// Top of the standby pin state control: port 8, port A, port B pins
// Assumes all inputs come from logic on clk; pins resolved outside
`include "pin_state_consts.vh"
module standby_pin_state_control (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Operating mode and power state
  input wire [2:0] op_mode,
  input wire hw_standby,
  input wire sw_standby,
  input wire bus_release_req,
  input wire standby_output_keep,
  // Bus release control bits
  input wire upper_addr_bit23_enable,
  input wire upper_addr_bit22_enable,
  input wire upper_addr_bit21_enable,
  input wire upper_addr_bit20_enable,
  // Chip select control bits
  input wire chip_select7_enable,
  input wire chip_select6_enable,
  input wire chip_select5_enable,
  input wire chip_select4_enable,
  // Bus functions
  input wire [23:20] addr_hi,
  input wire [7:0] chip_sel_n,
  // General purpose port data and direction
  input wire [4:2] p8_ddr,
  input wire [4:2] p8_dr,
  input wire [7:4] pa_ddr,
  input wire [7:4] pa_dr,
  input wire [3:0] pb_ddr,
  input wire [3:0] pb_dr,
  // Status
  output reg bus_released_ff,
  // Pins
  output wire [4:2] p8_out,
  output wire [4:2] p8_oe,
  output wire [7:4] pa_out,
  output wire [7:4] pa_oe,
  output wire [3:0] pb_out,
  output wire [3:0] pb_oe
);
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function in_range;
    input [2:0] m;
    input [2:0] lo;
    input [2:0] hi;
    begin
      in_range = (m >= lo) && (m <= hi);
    end
  endfunction
  wire ext_mode = in_range(op_mode, `MODE_EXT_LO, `MODE_ADDR_HI);
  wire addr_mode = in_range(op_mode, `MODE_ADDR_LO, `MODE_ADDR_HI);
  wire mode5 = (op_mode == `MODE_ADDR_HI);
  wire single_mode = (op_mode >= `MODE_SINGLE_LO);
  // ----------------------------------------
  // Power and bus state
  // ----------------------------------------
  reg [1:0] state;
  always @*
  begin
    if (hw_standby)
      state = `ST_HWSTBY;
    else if (sw_standby)
      state = `ST_SWSTBY;
    else if (bus_released_ff)
      state = `ST_BUSREL;
    else
      state = `ST_RUN;
  end
  wire nxt_bus_released = bus_release_req & ~single_mode
    & ~hw_standby;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      bus_released_ff <= 1'b0;
    else
      bus_released_ff <= nxt_bus_released;
  end
  // ----------------------------------------
  // Port A pins 7..4: high address bits
  // ----------------------------------------
  wire [7:4] pa_en_bits = {upper_addr_bit20_enable, upper_addr_bit23_enable,
    upper_addr_bit22_enable, upper_addr_bit21_enable};
  wire [7:4] pa_fn;
  assign pa_fn[6:4] = {3{addr_mode}} & ~pa_en_bits[6:4];
  assign pa_fn[7] = mode5 & ~pa_en_bits[7];
  wire [7:4] pa_val = {addr_hi[20], addr_hi[23], addr_hi[22], addr_hi[21]};
  genvar i;
  generate
    for (i = 4; i < 8; i = i + 1)
    begin : g_pa
      pin_cell u_cell (
        .clk(clk),
        .reset(reset),
        .state(state),
        .func_sel(pa_fn[i]),
        .func_val(pa_val[i]),
        .gpio_oe(pa_ddr[i]),
        .gpio_val(pa_dr[i]),
        .sw_float(pa_fn[i] & ~standby_output_keep),
        .sw_high(1'b0),
        .rel_float(pa_fn[i]),
        .pin_out_ff(pa_out[i]),
        .pin_oe_ff(pa_oe[i])
      );
    end
  endgenerate
  // ----------------------------------------
  // Port B pins 3..0: chip selects 4..7
  // ----------------------------------------
  wire [3:0] pb_fn = {4{ext_mode}} & {chip_select4_enable,
    chip_select5_enable, chip_select6_enable,
    chip_select7_enable};
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_pb
      pin_cell u_cell (
        .clk(clk),
        .reset(reset),
        .state(state),
        .func_sel(pb_fn[i]),
        .func_val(chip_sel_n[7 - i]),
        .gpio_oe(pb_ddr[i]),
        .gpio_val(pb_dr[i]),
        .sw_float(pb_fn[i] & ~standby_output_keep),
        .sw_high(pb_fn[i] & standby_output_keep),
        .rel_float(pb_fn[i]),
        .pin_out_ff(pb_out[i]),
        .pin_oe_ff(pb_oe[i])
      );
    end
  endgenerate
  // ----------------------------------------
  // Port 8 pins 4..2: chip selects 0..2
  // ----------------------------------------
  wire [4:2] p8_fn = {3{ext_mode}} & p8_ddr;
  generate
    for (i = 2; i < 5; i = i + 1)
    begin : g_p8
      pin_cell u_cell (
        .clk(clk),
        .reset(reset),
        .state(state),
        .func_sel(p8_fn[i]),
        .func_val(chip_sel_n[4 - i]),
        .gpio_oe(~ext_mode & p8_ddr[i]),
        .gpio_val(p8_dr[i]),
        .sw_float(ext_mode & ~(p8_ddr[i] & standby_output_keep)),
        .sw_high(p8_fn[i] & standby_output_keep),
        .rel_float(p8_fn[i]),
        .pin_out_ff(p8_out[i]),
        .pin_oe_ff(p8_oe[i])
      );
    end
  endgenerate
endmodule

/* standby_pin_state_control_tb_top.sv */
// Testbench for the standby pin state control
// Assumes the checker is bound from its own file
module standby_pin_state_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, hw = 0, sw = 0, rel = 0, keep = 0, released;
  logic [2:0] mode = 3'h3;
  logic [3:0] en = 4'h0, cs_en = 4'h0, pdr = 4'h6, pddr = 4'hF;
  logic [23:20] addr = 4'hB;
  logic [7:0] csn = 8'h5A;
  logic [10:0] out, oe, level;
  int err_total = 0, checks = 0, cyc = 0;
  standby_pin_state_control i_dut (.clk(clk), .reset(reset),
    .op_mode(mode), .hw_standby(hw), .sw_standby(sw),
    .bus_release_req(rel), .standby_output_keep(keep),
    .upper_addr_bit23_enable(en[3]), .upper_addr_bit22_enable(en[2]),
    .upper_addr_bit21_enable(en[1]), .upper_addr_bit20_enable(en[0]),
    .chip_select7_enable(cs_en[3]), .chip_select6_enable(cs_en[2]),
    .chip_select5_enable(cs_en[1]), .chip_select4_enable(cs_en[0]),
    .addr_hi(addr), .chip_sel_n(csn), .p8_ddr(pddr[2:0]), .p8_dr(pdr[2:0]),
    .pa_ddr(pddr), .pa_dr(pdr), .pb_ddr(pddr), .pb_dr(pdr),
    .bus_released_ff(released), .p8_out(out[10:8]), .p8_oe(oe[10:8]),
    .pa_out(out[7:4]), .pa_oe(oe[7:4]), .pb_out(out[3:0]), .pb_oe(oe[3:0]));
  far_side_pins i_far (.out(out), .oe(oe), .level(level));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [10:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic go(input logic [2:0] m, input logic h, s, r, k);
    @(negedge clk);
    {mode, hw, sw, rel, keep} = {m, h, s, r, k};
    repeat (2) @(negedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc > 2000)
    begin
      err_total++;
      results();
    end
  initial
  begin
    repeat (16) @(negedge clk);
    reset = 0;
    go(3'h3, 0, 0, 0, 0);
    chk("pa_out", out[6:4], addr[23:21]);
    go(3'h3, 0, 1, 0, 0);
    chk("pa_oe_sw", oe[6:4], 3'h0);
    go(3'h3, 0, 0, 1, 0);
    chk("pa_oe_rel", oe[6:4], 3'h0);
    chk("released", released, 1'b1);
    en = 4'hF;
    go(3'h3, 0, 0, 0, 0);
    go(3'h3, 0, 0, 1, 0);
    chk("pa_out", out[7:4], pdr);
    chk("pa_oe", oe[7:4], 4'hF);
    pdr = 4'h9;
    repeat (2) @(negedge clk);
    chk("pa_hold", out[7:4], 4'h6);
    pdr = 4'h6;
    en = 4'h0;
    go(3'h5, 0, 0, 0, 0);
    chk("pa7_out", out[7], addr[20]);
    en = 4'h1;
    go(3'h5, 0, 0, 0, 0);
    chk("pa7_io", out[7], pdr[3]);
    go(3'h5, 0, 1, 0, 0);
    pdr = 4'h9;
    repeat (2) @(negedge clk);
    chk("pa7_hold", {oe[7], out[7]}, 2'b10);
    pdr = 4'h6;
    en = 4'h0;
    go(3'h6, 0, 0, 1, 0);
    chk("released", released, 1'b0);
    cs_en = 4'hF;
    go(3'h1, 0, 0, 0, 0);
    chk("pb_out", out[3:0], 4'hA);
    chk("p8_out", out[10:8], 3'h2);
    go(3'h1, 0, 1, 0, 1);
    chk("pb_level", level[3:0], 4'hF);
    chk("p8_level", level[10:8], 3'h7);
    cs_en = 4'h0;
    go(3'h1, 0, 0, 0, 0);
    go(3'h1, 0, 1, 0, 0);
    chk("pb_out", out[3:0], pdr);
    pdr = 4'h9;
    repeat (2) @(negedge clk);
    chk("pb_hold", out[3:0], 4'h6);
    pdr = 4'h6;
    go(3'h1, 1, 1, 1, 1);
    chk("all_oe", oe, 11'h000);
    results();
  end
endmodule
